/* verilog/prti_pkg.sv */
/*
 * prti_pkg: register map, field positions, reset values and carrier structs
 * for the peripheral reset and input type register slice.
 * Assumes a 32-bit APB slave with word-aligned byte addresses.
 */
package prti_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [ADDR_W-1:0] PERIPHERAL_RESET_CTRL_OFS = 12'h00C;
    localparam logic [ADDR_W-1:0] PORTA_INPUT_TYPE_OFS      = 12'h030;
    localparam logic [ADDR_W-1:0] PORTB_INPUT_TYPE_OFS      = 12'h034;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [DATA_W-1:0] PERIPHERAL_RESET_CTRL_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] PORTA_INPUT_TYPE_RST      = 32'h0000_0000;
    localparam logic [DATA_W-1:0] PORTB_INPUT_TYPE_RST      = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // peripheral reset bit positions
    localparam int unsigned ANALOG_BLOCK_RESET_BIT   = 30;
    localparam int unsigned AUDIO_SERIAL_RESET_BIT   = 29;
    localparam int unsigned CONVERTER_RESET_BIT      = 28;
    localparam int unsigned COMPARATOR_RESET_BIT     = 22;
    localparam int unsigned PULSE_WIDTH_RESET_BIT    = 20;
    localparam int unsigned CHECKSUM_BLOCK_RESET_BIT = 19;
    localparam int unsigned FILTER_BLOCK_RESET_BIT   = 18;
    localparam int unsigned ASYNC_SERIAL_RESET_BIT   = 16;
    localparam int unsigned SPEAKER_DRIVER_RESET_BIT = 13;
    localparam int unsigned SYNC_SERIAL_RESET_BIT    = 12;
    localparam int unsigned TWO_WIRE_RESET_BIT       = 8;
    localparam int unsigned TIMER_ONE_RESET_BIT      = 7;
    localparam int unsigned TIMER_ZERO_RESET_BIT     = 6;

    // writable bits of the peripheral reset register; all others reserved
    localparam logic [DATA_W-1:0] PERIPHERAL_RESET_MASK = 32'h705D_31C0;

    ////////////////////////////////////////////////////////////////////////////
    // schmitt enable fields
    localparam int unsigned PORTA_PINS         = 16;
    localparam int unsigned PORTB_PINS         = 8;
    localparam int unsigned SCHMITT_ENABLE_LSB = 16;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } prti_apb_req_s;

    typedef struct packed {
        logic              pready;
        logic              pslverr;
        logic [DATA_W-1:0] prdata;
    } prti_apb_rsp_s;

    // one active-high reset line per peripheral block
    typedef struct packed {
        logic analog_block_reset;
        logic audio_serial_reset;
        logic converter_reset;
        logic comparator_reset;
        logic pulse_width_reset;
        logic checksum_block_reset;
        logic filter_block_reset;
        logic async_serial_reset;
        logic speaker_driver_reset;
        logic sync_serial_reset;
        logic two_wire_reset;
        logic timer_one_reset;
        logic timer_zero_reset;
    } prti_periph_rst_s;

endpackage : prti_pkg

/* verilog/prti_regs.sv */
/*
 * prti_regs: APB register slice holding the software peripheral reset lines
 * and the per-pin schmitt trigger enables of ports A and B.
 * Assumes the single system clock, the active-low asynchronous system reset,
 * and peripherals that take an active-high asynchronous reset from here.
 */
// Design decision made here: the APB interface to the registers.

////////////////////////////////////////////////////////////////////////////////
module prti_regs #(
    parameter int unsigned PA_PINS = prti_pkg::PORTA_PINS,
    parameter int unsigned PB_PINS = prti_pkg::PORTB_PINS
) (
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst_b,
    // apb slave
    input  wire prti_pkg::prti_apb_req_s   apb_req,
    output      prti_pkg::prti_apb_rsp_s   apb_rsp,
    // peripheral reset lines, active high
    output      prti_pkg::prti_periph_rst_s periph_rst,
    // pad schmitt trigger enables, active high
    output      logic [PA_PINS-1:0]        porta_schmitt_enable,
    output      logic [PB_PINS-1:0]        portb_schmitt_enable
);
    import prti_pkg::*;

    localparam logic [DATA_W-1:0] PA_MASK =
        DATA_W'(((64'h1 << PA_PINS) - 64'h1) << SCHMITT_ENABLE_LSB);
    localparam logic [DATA_W-1:0] PB_MASK =
        DATA_W'(((64'h1 << PB_PINS) - 64'h1) << SCHMITT_ENABLE_LSB);

    logic [DATA_W-1:0] peripheral_reset_ctrl_reg;
    logic [DATA_W-1:0] porta_input_type_reg;
    logic [DATA_W-1:0] portb_input_type_reg;
    logic [DATA_W-1:0] prdata_reg;
    logic [DATA_W-1:0] prdata_next;
    logic              wr_en;
    logic              rd_en;
    logic              hit;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode: zero wait state, every access completes in its first
    // access cycle; unmapped offsets answer with pslverr and read zero
    assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_en = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

    always_comb begin
        hit = 1'b1;
        prdata_next = '0;
        case (apb_req.paddr)
            PERIPHERAL_RESET_CTRL_OFS: prdata_next = peripheral_reset_ctrl_reg;
            PORTA_INPUT_TYPE_OFS:      prdata_next = porta_input_type_reg;
            PORTB_INPUT_TYPE_OFS:      prdata_next = portb_input_type_reg;
            default:                   hit = 1'b0;
        endcase
    end

    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !hit;
    assign apb_rsp.prdata  = prdata_reg;

    // read data captured in setup so it comes from a flip-flop in access
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prdata_reg <= '0;
        end else if (rd_en) begin
            prdata_reg <= prdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // peripheral reset register: level-held, software sets and clears
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            peripheral_reset_ctrl_reg <= PERIPHERAL_RESET_CTRL_RST;
        end else if (wr_en && apb_req.paddr == PERIPHERAL_RESET_CTRL_OFS) begin
            // no auto-return: the line holds until a 0 is written
            peripheral_reset_ctrl_reg <= apb_req.pwdata & PERIPHERAL_RESET_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // schmitt enable registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            porta_input_type_reg <= PORTA_INPUT_TYPE_RST;
        end else if (wr_en && apb_req.paddr == PORTA_INPUT_TYPE_OFS) begin
            porta_input_type_reg <= apb_req.pwdata & PA_MASK;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            portb_input_type_reg <= PORTB_INPUT_TYPE_RST;
        end else if (wr_en && apb_req.paddr == PORTB_INPUT_TYPE_OFS) begin
            portb_input_type_reg <= apb_req.pwdata & PB_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from register bits; the peripherals treat these as
    // asynchronous resets, so no logic sits between flop and line to glitch
    assign periph_rst.analog_block_reset   =
        peripheral_reset_ctrl_reg[ANALOG_BLOCK_RESET_BIT];
    assign periph_rst.checksum_block_reset =
        peripheral_reset_ctrl_reg[CHECKSUM_BLOCK_RESET_BIT];
    assign periph_rst.filter_block_reset   =
        peripheral_reset_ctrl_reg[FILTER_BLOCK_RESET_BIT];
    assign periph_rst.speaker_driver_reset =
        peripheral_reset_ctrl_reg[SPEAKER_DRIVER_RESET_BIT];
    // remaining peripheral lines
    assign periph_rst.audio_serial_reset   =
        peripheral_reset_ctrl_reg[AUDIO_SERIAL_RESET_BIT];
    assign periph_rst.converter_reset      =
        peripheral_reset_ctrl_reg[CONVERTER_RESET_BIT];
    assign periph_rst.comparator_reset     =
        peripheral_reset_ctrl_reg[COMPARATOR_RESET_BIT];
    assign periph_rst.pulse_width_reset    =
        peripheral_reset_ctrl_reg[PULSE_WIDTH_RESET_BIT];
    assign periph_rst.async_serial_reset   =
        peripheral_reset_ctrl_reg[ASYNC_SERIAL_RESET_BIT];
    assign periph_rst.sync_serial_reset    =
        peripheral_reset_ctrl_reg[SYNC_SERIAL_RESET_BIT];
    assign periph_rst.two_wire_reset       =
        peripheral_reset_ctrl_reg[TWO_WIRE_RESET_BIT];
    assign periph_rst.timer_one_reset      =
        peripheral_reset_ctrl_reg[TIMER_ONE_RESET_BIT];
    assign periph_rst.timer_zero_reset     =
        peripheral_reset_ctrl_reg[TIMER_ZERO_RESET_BIT];

    // pin n enable is field bit n
    assign porta_schmitt_enable =
        porta_input_type_reg[SCHMITT_ENABLE_LSB +: PA_PINS];
    assign portb_schmitt_enable =
        portb_input_type_reg[SCHMITT_ENABLE_LSB +: PB_PINS];

endmodule // prti_regs

/* tb/prti_regs_sva.sv */
/* prti_regs_sva: register and reserved-bit read checks on the slice's ports.
   Assumes one clock, rst_b active low, bound onto prti_regs. */
module prti_regs_sva
    import prti_pkg::*;
#(
    parameter int unsigned PA_PINS = 16,
    parameter int unsigned PB_PINS = 8
) (
    // clock and reset
    input wire logic                       clock,
    input wire logic                       rst_b,
    // bus and outputs
    input wire prti_pkg::prti_apb_req_s    apb_req,
    input wire prti_pkg::prti_apb_rsp_s    apb_rsp,
    input wire prti_pkg::prti_periph_rst_s periph_rst,
    input wire logic [PA_PINS-1:0]         porta_schmitt_enable,
    input wire logic [PB_PINS-1:0]         portb_schmitt_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////
    // access decode and expected reset lines from write data
    wire logic acc = apb_req.psel & apb_req.penable;
    wire logic wr_rc = acc & apb_req.pwrite & (apb_req.paddr == PERIPHERAL_RESET_CTRL_OFS);
    wire logic wr_pa = acc & apb_req.pwrite & (apb_req.paddr == PORTA_INPUT_TYPE_OFS);
    wire logic wr_pb = acc & apb_req.pwrite & (apb_req.paddr == PORTB_INPUT_TYPE_OFS);
    wire logic [31:0] d = apb_req.pwdata;
    wire prti_periph_rst_s rc_map = {d[30], d[29], d[28], d[22], d[20], d[19], d[18],
                                     d[16], d[13], d[12], d[8], d[7], d[6]};
    sequence s_wr_rc;
        wr_rc;
    endsequence
    property p_rc_wr; s_wr_rc |=> periph_rst == $past(rc_map); endproperty
    a_rc_wr: assert property (p_rc_wr) else $error("reset lines differ from write");
    property p_rc_hold; !wr_rc |=> $stable(periph_rst); endproperty
    a_rc_hold: assert property (p_rc_hold) else $error("reset lines moved");
    property p_pa_wr; wr_pa |=> porta_schmitt_enable == $past(d[31:16]); endproperty
    a_pa_wr: assert property (p_pa_wr) else $error("port a enables wrong");
    property p_pa_hold; !wr_pa |=> $stable(porta_schmitt_enable); endproperty
    a_pa_hold: assert property (p_pa_hold) else $error("port a enables moved");
    property p_pb_wr; wr_pb |=> portb_schmitt_enable == $past(d[23:16]); endproperty
    a_pb_wr: assert property (p_pb_wr) else $error("port b enables wrong");
    property p_pb_hold; !wr_pb |=> $stable(portb_schmitt_enable); endproperty
    a_pb_hold: assert property (p_pb_hold) else $error("port b enables moved");
    property p_rsv;
        acc && !apb_req.pwrite && apb_req.paddr == PERIPHERAL_RESET_CTRL_OFS
            |-> (apb_rsp.prdata & ~PERIPHERAL_RESET_MASK) == 32'h0000_0000;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
    property p_init;
        $rose(rst_b) |-> periph_rst == '0 && porta_schmitt_enable == '0
            && portb_schmitt_enable == '0;
    endproperty
    a_init: assert property (p_init) else $error("outputs not zero after reset");
endmodule // prti_regs_sva

bind prti_regs prti_regs_sva #(.PA_PINS(PA_PINS), .PB_PINS(PB_PINS)) i_sva (
    .clock(clock), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .periph_rst(periph_rst), .porta_schmitt_enable(porta_schmitt_enable),
    .portb_schmitt_enable(portb_schmitt_enable));

/* tb/tb_prti_regs.sv */
/* tb_prti_regs: directed bench driving the slice over apb.
   Assumes the slave ends each access when pready is high. */
module tb_prti_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import prti_pkg::*;
    logic             clock;
    logic             rst_b;
    prti_apb_req_s    req;
    prti_apb_rsp_s    rsp;
    prti_periph_rst_s prst;
    logic [15:0]      pa;
    logic [7:0]       pb;
    logic [31:0]      q;
    logic             e;
    int               fails;
    int               comparisons;
    prti_regs i_dut (.clock(clock), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp),
        .periph_rst(prst), .porta_schmitt_enable(pa), .portb_schmitt_enable(pb));
    // 4 ns clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic summarize();
        if (fails == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // one apb transfer; ends at a negedge so register outputs have settled
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge clock);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clock);
        req.penable <= 1'b1;
        do @(posedge clock); while (rsp.pready !== 1'b1); // watchdog bounds the wait
        q = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
        @(negedge clock);
    endtask
    task automatic t_reset();
        chk("prst", 0, prst);
        chk("pa", 0, pa);
        chk("pb", 0, pb);
        apb(0, PORTB_INPUT_TYPE_OFS, 0);
        chk("rd_pb", 0, q);
        chk("err_ok", 0, e);
    endtask
    task automatic t_bits();
        int pos[13] = '{30, 29, 28, 22, 20, 19, 18, 16, 13, 12, 8, 7, 6};
        for (int i = 0; i < 13; i++) begin
            apb(1, PERIPHERAL_RESET_CTRL_OFS, 32'h1 << pos[i]);
            chk("prst", 13'h1 << (12 - i), prst);
            apb(0, PERIPHERAL_RESET_CTRL_OFS, 0);
            chk("rd_rc", 32'h1 << pos[i], q);
        end
    endtask
    task automatic t_hold();
        apb(1, PERIPHERAL_RESET_CTRL_OFS, '1);
        repeat (20) @(posedge clock);
        chk("prst", 13'h1FFF, prst);
        apb(0, PERIPHERAL_RESET_CTRL_OFS, 0);
        chk("rd_rc", 32'h705D_31C0, q);
        apb(1, PERIPHERAL_RESET_CTRL_OFS, 0);
        chk("prst", 0, prst);
    endtask
    task automatic t_schmitt();
        apb(1, PORTA_INPUT_TYPE_OFS, '1);
        chk("pa", 16'hFFFF, pa);
        apb(0, PORTA_INPUT_TYPE_OFS, 0);
        chk("rd_pa", 32'hFFFF_0000, q);
        apb(1, PORTA_INPUT_TYPE_OFS, 32'h0001_0000);
        chk("pa", 16'h0001, pa);
        apb(1, PORTA_INPUT_TYPE_OFS, 32'h8000_0000);
        chk("pa", 16'h8000, pa);
        apb(1, PORTB_INPUT_TYPE_OFS, '1);
        chk("pb", 8'hFF, pb);
        apb(0, PORTB_INPUT_TYPE_OFS, 0);
        chk("rd_pb", 32'h00FF_0000, q);
        apb(1, PORTB_INPUT_TYPE_OFS, 32'h0001_0000);
        chk("pb", 8'h01, pb);
        apb(1, PORTB_INPUT_TYPE_OFS, 32'h0080_0000);
        chk("pb", 8'h80, pb);
        // reset in mid-run must clear live enables and live reset lines
        apb(1, PERIPHERAL_RESET_CTRL_OFS, '1);
        @(posedge clock);
        rst_b <= 1'b0;
        @(negedge clock);
        chk("prst", 0, prst);
        chk("pa", 0, pa);
        chk("pb", 0, pb);
        @(posedge clock);
        rst_b <= 1'b1;
    endtask
    task automatic t_unmapped();
        apb(1, 12'h010, '1);
        chk("err", 1, e);
        chk("prst", 0, prst);
        apb(0, 12'h010, 0);
        chk("rd_un", 0, q);
    endtask
    initial begin
        rst_b = 1'b0;
        req = '0;
        fails = 0;
        comparisons = 0;
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        @(negedge clock);
        t_reset();
        t_bits();
        t_hold();
        t_schmitt();
        t_unmapped();
        summarize();
    end
    // watchdog at 20 us: run needs well under 1 us
    initial begin
        #20000;
        fails++;
        summarize();
    end
endmodule // tb_prti_regs
